// ===== design/ulpi_pkg.sv
// ulpi_pkg: register map, command codes and controller offsets shared by both ends
// assumes both ends run on one clock and meet through ulpi_if
package ulpi_pkg;

    // ------------------------------------------------------------
    // immediate register set (6-bit addresses)
    // ------------------------------------------------------------
    localparam logic [5:0] MAKER_CODE_LOWER_BYTE = 6'h00;
    localparam logic [5:0] MAKER_CODE_UPPER_BYTE = 6'h01;
    localparam logic [5:0] PART_CODE_LOWER_BYTE = 6'h02;
    localparam logic [5:0] PART_CODE_UPPER_BYTE = 6'h03;
    localparam logic [5:0] TRANSCEIVER_FUNCTION_CONTROL = 6'h04;
    localparam logic [5:0] LINK_INTERFACE_CONTROL = 6'h07;
    localparam logic [5:0] DUAL_ROLE_CONTROL = 6'h0A;
    localparam logic [5:0] RISING_EDGE_IRQ_ENABLE = 6'h0D;
    localparam logic [5:0] FALLING_EDGE_IRQ_ENABLE = 6'h10;
    localparam logic [5:0] IRQ_SOURCE_STATE = 6'h13;
    localparam logic [5:0] IRQ_LATCHED_EVENTS = 6'h14;
    localparam logic [5:0] DIAGNOSTIC_SNAPSHOT = 6'h15;
    localparam logic [5:0] SPARE_STORAGE = 6'h16;
    localparam logic [5:0] RESERVED_FIRST = 6'h19;
    localparam logic [5:0] RESERVED_LAST = 6'h2E;
    localparam logic [5:0] EXTENDED_SET_ESCAPE = 6'h2F;
    localparam logic [5:0] VENDOR_AREA_FIRST = 6'h30;
    localparam logic [5:0] VENDOR_AREA_LAST = 6'h3C;
    localparam logic [5:0] POWER_MANAGEMENT_CONTROL = 6'h3D;
    localparam logic [7:0] EXTENDED_RESERVED_FIRST = 8'h40;

    // ------------------------------------------------------------
    // reset values and fields
    // ------------------------------------------------------------
    localparam logic [7:0] FUNCTION_CONTROL_RESET = 8'h41;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam int CORE_RESET_BIT = 5;

    // ------------------------------------------------------------
    // transmit command byte: [7:6] type, [5:0] address
    // ------------------------------------------------------------
    localparam logic [1:0] CMD_REG_WRITE = 2'h2;
    localparam logic [1:0] CMD_REG_READ = 2'h3;

    // ------------------------------------------------------------
    // controller registers, byte addresses
    // ------------------------------------------------------------
    localparam logic [3:0] CTRL_ORDER = 4'h0;
    localparam logic [3:0] CTRL_STATUS = 4'h4;
    localparam logic [3:0] CTRL_IRQ_STATUS = 4'h8;
    localparam logic [3:0] CTRL_IRQ_MASK = 4'hC;
    localparam int ORDER_READ_BIT = 8;
    localparam int ORDER_EXT_BIT = 9;
    localparam int IRQ_DONE = 0;
    localparam int IRQ_RXCMD = 1;
    localparam int IRQ_REFUSED = 2;
    localparam int IRQ_BITS = 3;

endpackage : ulpi_pkg

// ===== design/ulpi_if.sv
// ulpi_if: the shared 8-bit data bus with its direction, next and stop lines
// assumes both ends sit on the clock given here; the bus reads low when nobody drives
`timescale 1ns/10ps
interface ulpi_if (
    input wire logic clk
);
    logic dir;
    logic nxt;
    logic stp;
    logic [7:0] phy_dout;
    logic phy_oe;
    logic [7:0] link_dout;
    logic link_oe;
    logic [7:0] data;

    assign data = phy_oe ? phy_dout : (link_oe ? link_dout : 8'h00);

    modport phy (
        input stp,
        input data,
        output dir,
        output nxt,
        output phy_dout,
        output phy_oe
    );

    modport link (
        input dir,
        input nxt,
        input data,
        output stp,
        output link_dout,
        output link_oe
    );
endinterface : ulpi_if

// ===== design/ulpi_phy.sv
// ulpi_phy: transceiver end; bus turnaround, register set with write/set/clear aliases
// assumes the link obeys the turnaround and keeps off reserved addresses
//
// Summary of operation
// [R01] after reset phy leaves bus, link drives low
// [R02] phy raises dir to take bus
// [R03] link output enable cut combinationally by dir
// [R04] phy drives data one edge after dir
// [R05] phy drops dir and drive together
// [R06] link re-drives two cycles after dir falls
// [R07] write address replaces whole register
// [R08] set address ors data into register
// [R09] clear address clears bits masked by data
// [R10] read-only registers; write/set/clear addresses readable
// [R11] addresses 19h to 2Eh are reserved
// [R12] address 2Fh write is extended escape
// [R13] extended 00h-3Fh alias; 40h-FFh reserved
// [R14] vendor area 30h-3Ch, power control 3Dh-3Fh
// [R15] maker code bytes at 00h, 01h
// [R16] part code bytes at 02h, 03h
// [R17] core reset bit: dir high, clear, status
// [R18] writes to read-only/reserved change nothing
//
// Added by the designer: the plain strobed port.
`timescale 1ns/10ps
module ulpi_phy #(
    // identification codes: arbitrary values
    parameter logic [15:0] MAKER_CODE = 16'h5A5A,
    parameter logic [15:0] PART_CODE = 16'h0101,
    parameter int RESET_CYCLES = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // ulpi bus
    ulpi_if.phy bus,
    // user side
    input wire logic [7:0] irq_src,
    input wire logic [7:0] diag_in,
    output logic [7:0] function_control,
    output logic [7:0] interface_control,
    output logic [7:0] dual_role,
    output logic [7:0] power_control,
    output logic core_reset
);
    // the core reset counter is eight bits wide
    if (RESET_CYCLES < 1 || RESET_CYCLES > 255) begin : g_cycles_check
        $error("RESET_CYCLES out of range");
    end

    typedef enum logic [2:0] {
        IDLE, CMD_ACK, EXT_ACK, DATA_ACK, STOP, TURN, DRIVE, CORE_RST
    } phy_state_t;

    typedef struct packed {
        phy_state_t st;
        logic dir;
        logic nxt;
        logic oe;
        logic [7:0] dout;
        logic [5:0] addr;
        logic is_rd;
        logic ext;
        logic [7:0] ext_addr;
        logic [7:0] wdata;
        logic [7:0] func;
        logic [7:0] intf;
        logic [7:0] otg;
        logic [7:0] rise_en;
        logic [7:0] fall_en;
        logic [7:0] latched;
        logic [7:0] spare;
        logic [7:0] pwr;
        logic [7:0] src_prev;
        logic rx_pend;
        logic core_rst;
        logic [7:0] cnt;
    } phy_t;

    phy_t s_q;
    phy_t s_d;

    // ------------------------------------------------------------
    // register helpers
    // ------------------------------------------------------------
    function automatic logic in_trio(input logic [5:0] a, input logic [5:0] base);
        return (a >= base) && (a <= 6'(base + 6'h02));
    endfunction : in_trio

    function automatic logic [7:0] trio_write(input logic [7:0] cur, input logic [5:0] a,
                                              input logic [5:0] base, input logic [7:0] d);
        if (a == base) begin
            return d; // R07
        end else if (a == 6'(base + 6'h01)) begin
            return cur | d; // R08
        end else if (a == 6'(base + 6'h02)) begin
            return cur & ~d; // R09
        end
        return cur;
    endfunction : trio_write

    function automatic logic [7:0] read_value(input phy_t s, input logic [5:0] a);
        if (a == ulpi_pkg::MAKER_CODE_LOWER_BYTE) return MAKER_CODE[7:0]; // R15
        if (a == ulpi_pkg::MAKER_CODE_UPPER_BYTE) return MAKER_CODE[15:8]; // R15
        if (a == ulpi_pkg::PART_CODE_LOWER_BYTE) return PART_CODE[7:0]; // R16
        if (a == ulpi_pkg::PART_CODE_UPPER_BYTE) return PART_CODE[15:8]; // R16
        if (in_trio(a, ulpi_pkg::TRANSCEIVER_FUNCTION_CONTROL)) return s.func; // R10
        if (in_trio(a, ulpi_pkg::LINK_INTERFACE_CONTROL)) return s.intf; // R10
        if (in_trio(a, ulpi_pkg::DUAL_ROLE_CONTROL)) return s.otg; // R10
        if (in_trio(a, ulpi_pkg::RISING_EDGE_IRQ_ENABLE)) return s.rise_en; // R10
        if (in_trio(a, ulpi_pkg::FALLING_EDGE_IRQ_ENABLE)) return s.fall_en; // R10
        if (a == ulpi_pkg::IRQ_SOURCE_STATE) return irq_src;
        if (a == ulpi_pkg::IRQ_LATCHED_EVENTS) return s.latched;
        if (a == ulpi_pkg::DIAGNOSTIC_SNAPSHOT) return diag_in;
        if (in_trio(a, ulpi_pkg::SPARE_STORAGE)) return s.spare; // R10
        if (a >= ulpi_pkg::POWER_MANAGEMENT_CONTROL) return s.pwr; // R14
        // reserved, escape and vendor area read as zero
        return 8'h00; // R11 R14
    endfunction : read_value

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        logic [5:0] wa;
        logic wok;
        wa = s_q.ext ? s_q.ext_addr[5:0] : s_q.addr;
        wok = !s_q.ext || (s_q.ext_addr < ulpi_pkg::EXTENDED_RESERVED_FIRST); // R13
        s_d = s_q;
        case (s_q.st)
            IDLE: begin
                s_d.dir = 1'b0;
                s_d.oe = 1'b0;
                if (bus.data[7]) begin
                    s_d.addr = bus.data[5:0];
                    s_d.is_rd = (bus.data[7:6] == ulpi_pkg::CMD_REG_READ);
                    s_d.ext = 1'b0;
                    s_d.nxt = 1'b1;
                    s_d.st = CMD_ACK;
                end else if (s_q.rx_pend) begin
                    s_d.dir = 1'b1; // R02
                    s_d.is_rd = 1'b0;
                    s_d.st = TURN;
                end
            end
            CMD_ACK: begin
                if (s_q.is_rd) begin
                    s_d.nxt = 1'b0;
                    s_d.dir = 1'b1; // R02
                    s_d.st = TURN;
                end else if (s_q.addr == ulpi_pkg::EXTENDED_SET_ESCAPE) begin
                    s_d.ext = 1'b1; // R12
                    s_d.st = EXT_ACK;
                end else begin
                    s_d.st = DATA_ACK;
                end
            end
            EXT_ACK: begin
                s_d.ext_addr = bus.data;
                s_d.st = DATA_ACK;
            end
            DATA_ACK: begin
                s_d.wdata = bus.data;
                s_d.nxt = 1'b0;
                s_d.st = STOP;
            end
            STOP: begin
                if (bus.stp) begin
                    s_d.st = IDLE;
                    // read-only, reserved and vendor addresses match no trio
                    if (wok) begin // R18
                        s_d.func = trio_write(s_q.func, wa,
                            ulpi_pkg::TRANSCEIVER_FUNCTION_CONTROL, s_q.wdata);
                        s_d.intf = trio_write(s_q.intf, wa,
                            ulpi_pkg::LINK_INTERFACE_CONTROL, s_q.wdata);
                        s_d.otg = trio_write(s_q.otg, wa, ulpi_pkg::DUAL_ROLE_CONTROL, s_q.wdata);
                        s_d.rise_en = trio_write(s_q.rise_en, wa,
                            ulpi_pkg::RISING_EDGE_IRQ_ENABLE, s_q.wdata);
                        s_d.fall_en = trio_write(s_q.fall_en, wa,
                            ulpi_pkg::FALLING_EDGE_IRQ_ENABLE, s_q.wdata);
                        s_d.spare = trio_write(s_q.spare, wa, ulpi_pkg::SPARE_STORAGE, s_q.wdata);
                        s_d.pwr = trio_write(s_q.pwr, wa,
                            ulpi_pkg::POWER_MANAGEMENT_CONTROL, s_q.wdata); // R14
                    end
                    if (s_d.func[ulpi_pkg::CORE_RESET_BIT]) begin
                        s_d.dir = 1'b1; // R17
                        s_d.core_rst = 1'b1;
                        s_d.cnt = 8'(RESET_CYCLES - 1);
                        s_d.st = CORE_RST;
                    end
                end
            end
            TURN: begin
                // one turnaround cycle before the phy drives
                s_d.oe = 1'b1; // R04
                s_d.dout = s_q.is_rd ? read_value(s_q, s_q.addr) : irq_src;
                if (s_q.is_rd && s_q.addr == ulpi_pkg::IRQ_LATCHED_EVENTS) begin
                    s_d.latched = 8'h00;
                end
                s_d.st = DRIVE;
            end
            DRIVE: begin
                s_d.dir = 1'b0; // R05
                s_d.oe = 1'b0; // R05
                if (!s_q.is_rd) begin
                    s_d.rx_pend = 1'b0;
                end
                s_d.st = IDLE;
            end
            CORE_RST: begin
                if (s_q.cnt == 8'h00) begin
                    s_d.dir = 1'b0; // R17
                    s_d.core_rst = 1'b0;
                    s_d.func[ulpi_pkg::CORE_RESET_BIT] = 1'b0; // R17
                    s_d.rx_pend = 1'b1; // R17
                    s_d.st = IDLE;
                end else begin
                    s_d.cnt = s_q.cnt - 8'h01;
                end
            end
            default: begin
                s_d.st = IDLE;
            end
        endcase
        // source events win over any clear in the same cycle
        s_d.latched = s_d.latched | (irq_src & ~s_q.src_prev & s_q.rise_en)
                    | (~irq_src & s_q.src_prev & s_q.fall_en);
        if (irq_src != s_q.src_prev) begin
            s_d.rx_pend = 1'b1;
        end
        s_d.src_prev = irq_src;
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            s_q <= '0; // R01
            s_q.st <= IDLE;
            s_q.func <= ulpi_pkg::FUNCTION_CONTROL_RESET;
            s_q.intf <= ulpi_pkg::CONTROL_RESET;
            s_q.otg <= ulpi_pkg::CONTROL_RESET;
            s_q.pwr <= ulpi_pkg::CONTROL_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign bus.dir = s_q.dir;
    assign bus.nxt = s_q.nxt;
    assign bus.phy_oe = s_q.oe;
    assign bus.phy_dout = s_q.dout;
    assign function_control = s_q.func;
    assign interface_control = s_q.intf;
    assign dual_role = s_q.otg;
    assign power_control = s_q.pwr;
    assign core_reset = s_q.core_rst;

endmodule : ulpi_phy

// ===== design/ulpi_link.sv
// ulpi_link: controller end; issues register reads and writes, receives status bytes
// assumes software on a plain register port and a phy keeping the turnaround
`timescale 1ns/10ps
module ulpi_link (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // ulpi bus
    ulpi_if.link bus,
    // register port
    input wire logic [3:0] addr,
    input wire logic [31:0] wdata,
    input wire logic write,
    input wire logic read,
    output logic [31:0] rdata,
    output logic irq
);
    typedef enum logic [2:0] {
        IDLE, CMD, EXT, DATA, STP, RD_WAIT
    } link_state_t;

    typedef struct packed {
        link_state_t st;
        logic [7:0] dout;
        logic stp;
        logic drive;
        logic dir_q;
        logic is_rd;
        logic ext;
        logic [7:0] raddr;
        logic [7:0] wbyte;
        logic [7:0] rd_byte;
        logic [7:0] rxcmd;
        logic [ulpi_pkg::IRQ_BITS-1:0] irq_stat;
        logic [ulpi_pkg::IRQ_BITS-1:0] irq_mask;
        logic irq;
        logic [31:0] rdata;
    } link_t;

    link_t s_q;
    link_t s_d;

    function automatic logic refused(input logic [7:0] a, input logic rd, input logic ext);
        if (ext) begin
            return rd || (a >= ulpi_pkg::EXTENDED_RESERVED_FIRST); // R13
        end
        return (a > 8'h3F) || (a[5:0] == ulpi_pkg::EXTENDED_SET_ESCAPE)
            || (a[5:0] >= ulpi_pkg::RESERVED_FIRST && a[5:0] <= ulpi_pkg::RESERVED_LAST); // R11
    endfunction : refused

    always_comb begin
        logic [ulpi_pkg::IRQ_BITS-1:0] ev;
        logic rx_edge;
        ev = '0;
        s_d = s_q;
        s_d.dir_q = bus.dir;
        // re-drive only after dir has been low a full cycle
        s_d.drive = !bus.dir && !s_q.dir_q; // R06
        rx_edge = bus.dir && s_q.dir_q;
        s_d.stp = 1'b0;
        s_d.rdata = 32'h00000000;
        case (s_q.st)
            IDLE: begin
                s_d.dout = 8'h00; // R01
                if (rx_edge) begin
                    s_d.rxcmd = bus.data;
                    ev[ulpi_pkg::IRQ_RXCMD] = 1'b1;
                end
                if (write && addr == ulpi_pkg::CTRL_ORDER) begin
                    if (refused(wdata[7:0], wdata[ulpi_pkg::ORDER_READ_BIT],
                                wdata[ulpi_pkg::ORDER_EXT_BIT])) begin
                        ev[ulpi_pkg::IRQ_REFUSED] = 1'b1; // R11
                    end else begin
                        s_d.raddr = wdata[7:0];
                        s_d.is_rd = wdata[ulpi_pkg::ORDER_READ_BIT];
                        s_d.ext = wdata[ulpi_pkg::ORDER_EXT_BIT];
                        s_d.wbyte = wdata[23:16];
                        s_d.dout = {wdata[ulpi_pkg::ORDER_READ_BIT] ? ulpi_pkg::CMD_REG_READ
                                    : ulpi_pkg::CMD_REG_WRITE, wdata[ulpi_pkg::ORDER_EXT_BIT]
                                    ? ulpi_pkg::EXTENDED_SET_ESCAPE : wdata[5:0]};
                        s_d.st = CMD;
                    end
                end
            end
            CMD: begin
                if (bus.nxt) begin
                    if (s_q.is_rd) begin
                        s_d.dout = 8'h00;
                        s_d.st = RD_WAIT;
                    end else if (s_q.ext) begin
                        s_d.dout = s_q.raddr; // R12
                        s_d.st = EXT;
                    end else begin
                        s_d.dout = s_q.wbyte;
                        s_d.st = DATA;
                    end
                end
            end
            EXT: begin
                if (bus.nxt) begin
                    s_d.dout = s_q.wbyte;
                    s_d.st = DATA;
                end
            end
            DATA: begin
                if (bus.nxt) begin
                    s_d.dout = 8'h00;
                    s_d.stp = 1'b1;
                    s_d.st = STP;
                end
            end
            STP: begin
                ev[ulpi_pkg::IRQ_DONE] = 1'b1;
                s_d.st = IDLE;
            end
            RD_WAIT: begin
                if (rx_edge) begin
                    s_d.rd_byte = bus.data;
                    ev[ulpi_pkg::IRQ_DONE] = 1'b1;
                    s_d.st = IDLE;
                end
            end
            default: begin
                s_d.st = IDLE;
            end
        endcase
        if (read) begin
            case (addr)
                ulpi_pkg::CTRL_STATUS: begin
                    s_d.rdata = {8'h00, s_q.rxcmd, s_q.rd_byte, 7'h00, s_q.st != IDLE};
                end
                ulpi_pkg::CTRL_IRQ_STATUS: s_d.rdata = 32'(s_q.irq_stat);
                ulpi_pkg::CTRL_IRQ_MASK: s_d.rdata = 32'(s_q.irq_mask);
                default: s_d.rdata = 32'h00000000;
            endcase
        end
        if (write && addr == ulpi_pkg::CTRL_IRQ_MASK) begin
            s_d.irq_mask = wdata[ulpi_pkg::IRQ_BITS-1:0];
        end
        // new events win over a write-one clear
        if (write && addr == ulpi_pkg::CTRL_IRQ_STATUS) begin
            s_d.irq_stat = s_q.irq_stat & ~wdata[ulpi_pkg::IRQ_BITS-1:0];
        end
        s_d.irq_stat = s_d.irq_stat | ev;
        s_d.irq = |(s_d.irq_stat & s_d.irq_mask);
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            s_q <= '0;
            s_q.st <= IDLE;
            s_q.drive <= 1'b1; // R01
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign bus.link_oe = s_q.drive && !bus.dir; // R03
    assign bus.link_dout = s_q.dout;
    assign bus.stp = s_q.stp;
    assign rdata = s_q.rdata;
    assign irq = s_q.irq;

endmodule : ulpi_link

// ===== verif/ulpi_assertions.sv
// ulpi_assertions: turnaround and idle checks on the shared ulpi lines
// assumes one clock and the async high reset of both ends
`timescale 1ns/10ps
module ulpi_assertions (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // ulpi lines
    input wire logic dir,
    input wire logic stp,
    input wire logic phy_oe,
    input wire logic link_oe,
    input wire logic [7:0] link_dout
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    // ------------------------------------------------------------
    // turnaround steps
    // ------------------------------------------------------------
    sequence bus_taken;
        !dir ##1 dir;
    endsequence
    sequence bus_given;
        dir ##1 !dir;
    endsequence
    a_reset_idle: assert property ($fell(reset) |-> !dir && !phy_oe && link_oe && link_dout == 8'h00)
        else $error("bus not idle after reset");
    a_one_driver: assert property (!(phy_oe && link_oe))
        else $error("both ends drive the bus");
    a_link_yields: assert property (dir |-> !link_oe)
        else $error("link drives while dir high");
    a_turn_wait: assert property (bus_taken |-> !phy_oe)
        else $error("phy drives in turnaround cycle");
    a_phy_in_dir: assert property (phy_oe |-> dir)
        else $error("phy drives without dir");
    a_phy_release: assert property (bus_given |-> !phy_oe)
        else $error("phy still drives after dir fell");
    a_link_delay: assert property (bus_given |-> !link_oe ##1 !link_oe)
        else $error("link drives too soon after dir fell");
    a_stp_pulse: assert property (stp |-> !dir ##1 !stp)
        else $error("stop not a single cycle");
endmodule : ulpi_assertions

// ===== verif/ulpi_register_map_turnaround_test.sv
// ulpi_register_map_turnaround_test: both ends joined, driven through the link register port
// assumes the controller map of ulpi_pkg and a 20 ns clock
`timescale 1ns/10ps
module ulpi_register_map_turnaround_test;
    localparam logic [15:0] MAKER = 16'h3C96; // arbitrary value
    localparam logic [15:0] PART = 16'h7E21; // arbitrary value
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [3:0] addr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic write = 1'b0;
    logic read = 1'b0;
    logic [7:0] irq_src = 8'h00;
    logic [7:0] diag_in = 8'h00;
    logic [31:0] rdata;
    logic irq;
    logic [7:0] fctl, ictl, drole, pctl;
    logic core_reset;
    logic [5:0] bases [7] = '{6'h04, 6'h07, 6'h0A, 6'h0D, 6'h10, 6'h16, 6'h3D};
    int error_cnt = 0;
    int compares = 0;
    int cycles = 0;
    always #10 clk = ~clk;
    ulpi_if ulpi_if_i (.clk(clk));
    ulpi_phy #(.MAKER_CODE(MAKER), .PART_CODE(PART), .RESET_CYCLES(20)) ulpi_phy_i (
        .clk(clk), .reset(reset), .bus(ulpi_if_i), .irq_src(irq_src), .diag_in(diag_in),
        .function_control(fctl), .interface_control(ictl), .dual_role(drole),
        .power_control(pctl), .core_reset(core_reset));
    ulpi_link ulpi_link_i (.clk(clk), .reset(reset), .bus(ulpi_if_i), .addr(addr),
        .wdata(wdata), .write(write), .read(read), .rdata(rdata), .irq(irq));
    ulpi_assertions ulpi_assertions_i (.clk(clk), .reset(reset), .dir(ulpi_if_i.dir),
        .stp(ulpi_if_i.stp), .phy_oe(ulpi_if_i.phy_oe), .link_oe(ulpi_if_i.link_oe),
        .link_dout(ulpi_if_i.link_dout));
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [7:0] id_byte(input logic [1:0] i);
        id_byte = i[1] ? PART[8*i[0] +: 8] : MAKER[8*i[0] +: 8];
    endfunction : id_byte
    task automatic results();
        $display("compares %0d errors %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : results
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk8
    task automatic chk1(input logic got, input logic exp);
        chk8({7'h00, got}, {7'h00, exp});
    endtask : chk1
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        write <= 1'b1;
        @(posedge clk);
        write <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        read <= 1'b1;
        @(posedge clk);
        read <= 1'b0;
        #1 d = rdata;
    endtask : rd
    task automatic op(input logic rdn, input logic ext, input logic [7:0] a,
                      input logic [7:0] d, output logic [7:0] v);
        logic [31:0] s;
        int n;
        wr(ulpi_pkg::CTRL_ORDER, {8'h00, d, 6'h00, ext, rdn, a});
        n = 0;
        do begin
            rd(ulpi_pkg::CTRL_STATUS, s);
            n++;
        end while (s[0] !== 1'b0 && n < 60);
        if (s[0] !== 1'b0) error_cnt++;
        v = s[15:8];
    endtask : op
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            error_cnt++;
            results();
        end
    end
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        logic [7:0] v, m, a, b, c, e;
        logic [31:0] s;
        void'($urandom(31602));
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            op(1'b1, 1'b0, 8'(i), 8'h00, v);
            chk8(v, id_byte(2'(i)));
        end
        foreach (bases[k]) begin
            a = 8'($urandom) & 8'hDF;
            b = 8'($urandom) & 8'hDF;
            c = 8'($urandom);
            m = ((a | b) & ~c);
            op(1'b0, 1'b0, {2'b00, bases[k]}, a, v);
            op(1'b0, 1'b0, {2'b00, bases[k] + 6'h1}, b, v);
            op(1'b0, 1'b0, {2'b00, bases[k] + 6'h2}, c, v);
            for (int j = 0; j < 3; j++) begin
                op(1'b1, 1'b0, {2'b00, bases[k] + 6'(j)}, 8'h00, v);
                chk8(v, m);
            end
            if (k < 3) chk8(k == 0 ? fctl : (k == 1 ? ictl : drole), m);
            if (k == 3) e = m;
        end
        chk8(pctl, m);
        @(posedge clk) diag_in <= 8'($urandom);
        op(1'b0, 1'b0, 8'h00, 8'hFF, v);
        op(1'b0, 1'b0, 8'h15, 8'hFF, v);
        op(1'b1, 1'b0, 8'h00, 8'h00, v);
        chk8(v, MAKER[7:0]);
        op(1'b1, 1'b0, 8'h15, 8'h00, v);
        chk8(v, diag_in);
        op(1'b0, 1'b0, 8'h30, 8'h5A, v);
        op(1'b1, 1'b0, 8'h30, 8'h00, v);
        chk8(v, 8'h00);
        op(1'b0, 1'b1, 8'h16, 8'hA5, v);
        op(1'b1, 1'b0, 8'h16, 8'h00, v);
        chk8(v, 8'hA5);
        rd(ulpi_pkg::CTRL_IRQ_STATUS, s);
        chk1(s[ulpi_pkg::IRQ_DONE], 1'b1);
        wr(ulpi_pkg::CTRL_IRQ_STATUS, 32'h7);
        wr(ulpi_pkg::CTRL_IRQ_MASK, 32'h4);
        wr(ulpi_pkg::CTRL_ORDER, 32'h20);
        repeat (3) @(posedge clk);
        #1 chk1(irq, 1'b1);
        wr(ulpi_pkg::CTRL_IRQ_STATUS, 32'h4);
        repeat (2) @(posedge clk);
        #1 chk1(irq, 1'b0);
        wr(ulpi_pkg::CTRL_ORDER, 32'h240);
        repeat (3) @(posedge clk);
        #1 chk1(irq, 1'b1);
        wr(ulpi_pkg::CTRL_IRQ_MASK, 32'h0);
        repeat (2) @(posedge clk);
        #1 chk1(irq, 1'b0);
        @(posedge clk) irq_src <= 8'($urandom) | 8'h01;
        repeat (12) @(posedge clk);
        rd(ulpi_pkg::CTRL_STATUS, s);
        chk8(s[23:16], irq_src);
        op(1'b1, 1'b0, 8'h13, 8'h00, v);
        chk8(v, irq_src);
        op(1'b1, 1'b0, 8'h14, 8'h00, v);
        chk8(v, irq_src & e);
        op(1'b0, 1'b0, 8'h05, 8'h20, v);
        chk1(core_reset, 1'b1);
        chk1(ulpi_if_i.dir, 1'b1);
        repeat (40) @(posedge clk);
        #1 chk1(core_reset, 1'b0);
        op(1'b1, 1'b0, 8'h04, 8'h00, v);
        chk1(v[ulpi_pkg::CORE_RESET_BIT], 1'b0);
        rd(ulpi_pkg::CTRL_STATUS, s);
        chk8(s[23:16], irq_src);
        rd(ulpi_pkg::CTRL_IRQ_STATUS, s);
        chk1(s[ulpi_pkg::IRQ_RXCMD], 1'b1);
        results();
    end
endmodule : ulpi_register_map_turnaround_test
